//--- gpo_pll_gain_offset_config.v
// Configuration bank: GPO override, preset, ramp, gain and PLL frequency word
`timescale 1ns/1ps
`include "gpo_cfg_map.vh"
module gpo_pll_gain_offset_config #(
   parameter TX_DUR_WIDTH = 8,
   parameter RX_DUR_WIDTH = 8
) (
   input wire sys_clk,
   input wire resetn,
   input wire sdi_clk,
   input wire sdi_data,
   input wire sdi_enable_n,
   input wire tx_start_input,
   input wire rx_enable_input,
   input wire override_enable,
   input wire [2:0] rx_override_pattern,
   input wire [TX_DUR_WIDTH-1:0] tx_override_duration,
   input wire [RX_DUR_WIDTH-1:0] rx_override_duration,
   input wire [1:0] base_frequency_select,
   output reg general_output_bit_three,
   output reg general_output_bit_two,
   output reg general_output_bit_one,
   output reg [1:0] pll_preset_select,
   output reg ramp_table_select,
   output reg [4:0] ramp_quarter_symbols,
   output reg signed [7:0] digital_gain_db,
   output reg [`REG_WIDTH-1:0] gpo_ramp_gain_config,
   output reg [`REG_WIDTH-1:0] pll_frequency_offset,
   output reg [`REG_WIDTH-1:0] afc_signed_offset,
   output reg signed [47:0] lock_freq_fine
);
   localparam ST_IDLE = 3'b001;
   localparam ST_TX = 3'b010;
   localparam ST_RX = 3'b100;

   wire wr_strobe;
   wire [`ADDR_WIDTH-1:0] wr_addr;
   wire [`REG_WIDTH-1:0] wr_data;
   reg [1:0] txs_sync;
   reg [1:0] rxs_sync;
   reg [1:0] ovr_sync;
   reg txs_prev;
   reg rxs_prev;
   reg [2:0] state;
   reg [15:0] timer;
   reg [2:0] next_pins;
   reg signed [47:0] next_freq;
   reg signed [47:0] base_term;
   reg signed [47:0] frequency_offset_word_term;
   reg signed [47:0] afc_term;

   serial_reg_port i_serial_reg_port (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .sdi_clk(sdi_clk),
      .sdi_data(sdi_data),
      .sdi_enable_n(sdi_enable_n),
      .wr_strobe(wr_strobe),
      .wr_addr(wr_addr),
      .wr_data(wr_data)
   );

   // Gain in dB from the 4-bit code
   function signed [7:0] gain_db;
      input [3:0] code;
      begin
         if (code >= `GAIN_MAX_CODE) begin
            gain_db = 8'sd60;
         end else begin
            gain_db = $signed({4'h0, code}) * 8'sd6 - 8'sd18;
         end
      end
   endfunction

   // Base frequency in kHz for the base_frequency_select input code
   function [31:0] base_khz;
      input [1:0] sel;
      begin
         case (sel)
            2'b00: base_khz = 32'd0;
            2'b01: base_khz = `BASE_832_KHZ;
            default: base_khz = `BASE_1664_KHZ;
         endcase
      end
   endfunction

   // The lock frequency is carried in kHz scaled by 2^24. In these units the
   // 5 kHz offset step and the 26 MHz/2^24 AFC step are both exact integers,
   // so the word carries no rounding. Divider settings do not enter the sum,
   // which keeps the programmed relation whatever the dividers are set to.
   always @* begin
      base_term = $signed({16'h0000, base_khz(base_frequency_select)});
      frequency_offset_word_term = $signed({30'h0, pll_frequency_offset}) *
                  $signed({16'h0000, `FREQUENCY_OFFSET_WORD_STEP_KHZ});
      // Sign extension lets a negative AFC word pull the frequency down
      afc_term = $signed({{30{afc_signed_offset[17]}}, afc_signed_offset}) *
                 `AFC_STEP_FINE;
      next_freq = ((base_term + frequency_offset_word_term) <<< `FINE_SHIFT) + afc_term;
      // Programmed bits unless an override pattern is running
      next_pins = gpo_ramp_gain_config[`GPO_MSB:`GPO_LSB];
      if (state == ST_TX) begin
         next_pins = gpo_ramp_gain_config[`TX_PAT_MSB:`TX_PAT_LSB];
      end else if (state == ST_RX) begin
         next_pins = rx_override_pattern;
      end
   end

   // Host writes land one cycle after the strobe; unmapped addresses fall
   // through the default branch. Reserved bits are kept as written.
   always @(posedge sys_clk) begin
      if (!resetn) begin
         gpo_ramp_gain_config <= `CFG_RESET;
         pll_frequency_offset <= `FREQUENCY_OFFSET_WORD_RESET;
         afc_signed_offset <= `AFC_RESET;
      end else if (wr_strobe) begin
         case (wr_addr)
            `ADDR_GPO_RAMP_GAIN_CONFIG: gpo_ramp_gain_config <= wr_data;
            `ADDR_PLL_FREQUENCY_OFFSET: pll_frequency_offset <= wr_data;
            `ADDR_AFC_SIGNED_OFFSET: afc_signed_offset <= wr_data;
            default: ;
         endcase
      end
   end

   // Requests and the enable come from other domains: two flip-flops each.
   // The previous-level flops reset low, the idle level of both requests,
   // so the release of reset never looks like a rising request.
   always @(posedge sys_clk) begin
      if (!resetn) begin
         txs_sync <= 2'h0;
         rxs_sync <= 2'h0;
         ovr_sync <= 2'h0;
         txs_prev <= 1'b0;
         rxs_prev <= 1'b0;
      end else begin
         txs_sync <= {txs_sync[0], tx_start_input};
         rxs_sync <= {rxs_sync[0], rx_enable_input};
         ovr_sync <= {ovr_sync[0], override_enable};
         txs_prev <= txs_sync[1];
         rxs_prev <= rxs_sync[1];
      end
   end

   // Override sequencer. While override is enabled, a synced rising request starts its pattern,
   // which stands for duration plus one cycles; transmit wins when both rise together.
   always @(posedge sys_clk) begin
      if (!resetn) begin
         state <= ST_IDLE;
         timer <= 16'h0000;
      end else begin
         case (state)
            ST_IDLE: begin
               if (ovr_sync[1] && txs_sync[1] && !txs_prev) begin
                  state <= ST_TX;
                  timer <= {{(16-TX_DUR_WIDTH){1'b0}}, tx_override_duration};
               end else if (ovr_sync[1] && rxs_sync[1] && !rxs_prev) begin
                  state <= ST_RX;
                  timer <= {{(16-RX_DUR_WIDTH){1'b0}}, rx_override_duration};
               end
            end
            ST_TX, ST_RX: begin
               // Pattern ends when the duration expires, the request drops or enable clears
               if (!ovr_sync[1] || timer == 16'h0000 ||
                   (state == ST_TX ? !txs_sync[1] : !rxs_sync[1])) begin
                  state <= ST_IDLE;
               end else begin
                  timer <= timer - 16'h0001;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Pins follow the sequencer one cycle later, each from its own flip-flop
   always @(posedge sys_clk) begin
      if (!resetn) begin
         general_output_bit_three <= 1'b0;
         general_output_bit_two <= 1'b0;
         general_output_bit_one <= 1'b0;
      end else begin
         {general_output_bit_three, general_output_bit_two, general_output_bit_one} <=
            next_pins;
      end
   end

   // Controls derived from the stored words follow them one cycle later
   always @(posedge sys_clk) begin
      if (!resetn) begin
         pll_preset_select <= 2'h0;
         ramp_table_select <= 1'b0;
         ramp_quarter_symbols <= `RAMP_LONG_QS;
         digital_gain_db <= 8'sd0;
         lock_freq_fine <= 48'sd0;
      end else begin
         pll_preset_select <= gpo_ramp_gain_config[`PRESET_MSB:`PRESET_LSB];
         ramp_table_select <= gpo_ramp_gain_config[`RAMP_TABLE_BIT];
         ramp_quarter_symbols <= gpo_ramp_gain_config[`SHORT_RAMP_BIT] ?
            `RAMP_SHORT_QS : `RAMP_LONG_QS;
         digital_gain_db <= gain_db(gpo_ramp_gain_config[`GAIN_MSB:`GAIN_LSB]);
         lock_freq_fine <= next_freq;
      end
   end
endmodule // gpo_pll_gain_offset_config

//--- gpo_cfg_map.vh
// Register offsets, field positions, reset values and timing counts for the config bank
`ifndef GPO_CFG_MAP_VH
`define GPO_CFG_MAP_VH
`define ADDR_GPO_RAMP_GAIN_CONFIG 6'h02
`define ADDR_PLL_FREQUENCY_OFFSET 6'h03
`define ADDR_AFC_SIGNED_OFFSET 6'h04
`define REG_WIDTH 18
`define ADDR_WIDTH 6
`define GPO_MSB 17
`define GPO_LSB 15
`define TX_PAT_MSB 14
`define TX_PAT_LSB 12
`define PRESET_MSB 11
`define PRESET_LSB 10
`define RAMP_TABLE_BIT 7
`define SHORT_RAMP_BIT 6
`define GAIN_MSB 3
`define GAIN_LSB 0
`define CFG_RESET 18'h00003
`define FREQUENCY_OFFSET_WORD_RESET 18'h00000
`define AFC_RESET 18'h00000
`define RAMP_LONG_QS 5'h10
`define RAMP_SHORT_QS 5'h0D
`define GAIN_MAX_CODE 4'hD
`define BASE_832_KHZ 32'd832000
`define BASE_1664_KHZ 32'd1664000
`define FREQUENCY_OFFSET_WORD_STEP_KHZ 32'd5
`define FINE_SHIFT 24
`define AFC_STEP_FINE 48'sh6590
`endif

//--- serial_reg_port.v
// Three-wire serial write port: shifts a 6-bit address and 18-bit data word
`timescale 1ns/1ps
`include "gpo_cfg_map.vh"
module serial_reg_port (
   input wire sys_clk,
   input wire resetn,
   input wire sdi_clk,
   input wire sdi_data,
   input wire sdi_enable_n,
   output reg wr_strobe,
   output reg [`ADDR_WIDTH-1:0] wr_addr,
   output reg [`REG_WIDTH-1:0] wr_data
);
   reg [2:0] clk_sync;
   reg [1:0] data_sync;
   reg [2:0] en_sync;
   reg [23:0] shift;
   reg [4:0] count;

   always @(posedge sys_clk) begin
      if (!resetn) begin
         clk_sync <= 3'h0;
         data_sync <= 2'h0;
         en_sync <= 3'h7;
         shift <= 24'h000000;
         count <= 5'h00;
         wr_strobe <= 1'b0;
         wr_addr <= 6'h00;
         wr_data <= 18'h00000;
      end else begin
         clk_sync <= {clk_sync[1:0], sdi_clk};
         data_sync <= {data_sync[0], sdi_data};
         en_sync <= {en_sync[1:0], sdi_enable_n};
         wr_strobe <= 1'b0;
         if (en_sync[1]) begin
            count <= 5'h00;
         end else if (clk_sync[1] && !clk_sync[2]) begin
            // Address first, MSB first, then data MSB first
            shift <= {shift[22:0], data_sync[1]};
            if (count != 5'h18) begin
               count <= count + 5'h01;
            end
         end
         // Word is committed when enable rises after 24 or more bits; the last 24 shifted are kept
         if (en_sync[1] && !en_sync[2] && count == 5'h18) begin
            wr_strobe <= 1'b1;
            wr_addr <= shift[23:18];
            wr_data <= shift[17:0];
         end
      end
   end
endmodule // serial_reg_port

//--- host_serial_model.sv
// Behavioural host that writes registers over the three-wire serial port
`timescale 1ns/1ps
module host_serial_model (
   input wire sys_clk,
   output reg sdi_clk,
   output reg sdi_data,
   output reg sdi_enable_n
);
   integer k;
   reg [23:0] frame;
   initial begin
      sdi_clk = 1'b0;
      sdi_data = 1'b0;
      sdi_enable_n = 1'b1;
   end
   task write(input [5:0] addr, input [17:0] data);
      begin
         frame = {addr, (addr == 6'h02) ? data & 18'h3FCCF : data};
         sdi_enable_n = 1'b0;
         for (k = 23; k >= 0; k = k - 1) begin
            sdi_clk = 1'b0;
            sdi_data = frame[k];
            repeat (4) @(negedge sys_clk);
            sdi_clk = 1'b1;
            repeat (4) @(negedge sys_clk);
         end
         sdi_clk = 1'b0;
         repeat (4) @(negedge sys_clk);
         sdi_enable_n = 1'b1;
         // Released line shows the inverse of the last bit
         sdi_data = ~frame[0];
         // Enable must be seen high before the next frame may begin
         repeat (4) @(negedge sys_clk);
      end
   endtask
endmodule // host_serial_model

//--- gpo_cfg_checker.sv
// Port assertions for the configuration bank
`timescale 1ns/1ps
module gpo_cfg_checker (
   input wire sys_clk,
   input wire resetn,
   input wire tx_start_input,
   input wire rx_enable_input,
   input wire override_enable,
   input wire [2:0] rx_override_pattern,
   input wire [1:0] base_frequency_select,
   input wire general_output_bit_three,
   input wire general_output_bit_two,
   input wire general_output_bit_one,
   input wire [1:0] pll_preset_select,
   input wire ramp_table_select,
   input wire [4:0] ramp_quarter_symbols,
   input wire signed [7:0] digital_gain_db,
   input wire [17:0] gpo_ramp_gain_config,
   input wire [17:0] pll_frequency_offset,
   input wire [17:0] afc_signed_offset,
   input wire signed [47:0] lock_freq_fine
);
   wire [2:0] pins = {general_output_bit_three, general_output_bit_two, general_output_bit_one};
   wire [17:0] cfg = gpo_ramp_gain_config;
   function [47:0] freq_ref(input [1:0] sel, input [17:0] frequency_offset_word, input [17:0] afc);
      freq_ref = (((sel == 2'h0) ? 48'h0 : sel[1] ? 48'd1664000 : 48'd832000) + frequency_offset_word * 48'h5)
         * 48'h1000000 + {{30{afc[17]}}, afc} * 48'd26000;
   endfunction
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence quiet_s;
      (!tx_start_input && !rx_enable_input && $stable(cfg))[*6];
   endsequence
   sequence tx_go_s;
      (override_enable && !rx_enable_input)[*4] ##1 $rose(tx_start_input);
   endsequence
   sequence rx_go_s;
      (override_enable && !tx_start_input)[*4] ##1 $rose(rx_enable_input);
   endsequence
   idle_pins_a: assert property (quiet_s |-> pins == cfg[17:15])
      else $error("pins differ from programmed bits");
   tx_pattern_a: assert property (tx_go_s |-> ##[1:8] pins == cfg[14:12])
      else $error("transmit pattern not shown");
   rx_pattern_a: assert property (rx_go_s |-> ##[1:8] pins == rx_override_pattern)
      else $error("receive pattern not shown");
   table_select_a: assert property (pll_preset_select == $past(cfg[11:10])
      && ramp_table_select == $past(cfg[7])) else $error("select outputs wrong");
   ramp_len_a: assert property (ramp_quarter_symbols == ($past(cfg[6]) ? 5'h0D : 5'h10))
      else $error("ramp length wrong");
   gain_step_a: assert property (digital_gain_db ==
      ($past(cfg[3:0]) > 4'hC ? 8'h3C : $past(cfg[3:0]) * 8'h06 - 8'h12)) else $error("gain wrong");
   lock_freq_a: assert property ($past(resetn) |-> lock_freq_fine == freq_ref(
      $past(base_frequency_select), $past(pll_frequency_offset), $past(afc_signed_offset)))
      else $error("frequency wrong");
   reset_value_a: assert property (disable iff (1'b0) !resetn |=> cfg == 18'h00003
      && pll_frequency_offset == 18'h0 && afc_signed_offset == 18'h0) else $error("reset wrong");
endmodule // gpo_cfg_checker
bind gpo_pll_gain_offset_config gpo_cfg_checker i_gpo_cfg_checker (.*);

//--- gpo_pll_gain_offset_config_bench.sv
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
module gpo_pll_gain_offset_config_bench;
   reg sys_clk = 1'b0, resetn = 1'b0, tx_start_input = 1'b0, rx_enable_input = 1'b0;
   reg override_enable = 1'b0;
   reg [2:0] rx_override_pattern = 3'h0;
   reg [7:0] tx_override_duration = 8'h00, rx_override_duration = 8'h00;
   reg [1:0] base_frequency_select = 2'h0;
   wire sdi_clk, sdi_data, sdi_enable_n, ramp_table_select;
   wire general_output_bit_three, general_output_bit_two, general_output_bit_one;
   wire [1:0] pll_preset_select;
   wire [4:0] ramp_quarter_symbols;
   wire signed [7:0] digital_gain_db;
   wire [17:0] gpo_ramp_gain_config, pll_frequency_offset, afc_signed_offset;
   wire signed [47:0] lock_freq_fine;
   reg [31:0] seed = 32'h00000037;
   reg [17:0] cfg, frequency_offset_word, afc;
   integer err_count = 0, check_count = 0, i;
   always #4 sys_clk = ~sys_clk;
   host_serial_model i_host_serial_model (.*);
   gpo_pll_gain_offset_config i_gpo_pll_gain_offset_config (.*);
   function [17:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed[17:0];
   endfunction
   function [2:0] idle_pins(input [17:0] c);
      idle_pins = c[17:15];
   endfunction
   function [2:0] exp_pins(input [17:0] c, input [2:0] rxp, input ovr, input tx);
      exp_pins = !ovr ? c[17:15] : tx ? c[14:12] : rxp;
   endfunction
   function [7:0] exp_gain(input [3:0] code);
      exp_gain = (code > 4'hC) ? 8'h3C : {4'h0, code} * 8'h06 - 8'h12;
   endfunction
   function [47:0] exp_freq(input [1:0] sel, input [17:0] o, input [17:0] a);
      exp_freq = ((sel[1] ? 48'h196400 : sel[0] ? 48'h0CB200 : 48'h0) + o * 48'h5) * 48'h1000000
         + {{30{a[17]}}, a} * 48'h6590;
   endfunction
   task check_word(input [47:0] got, input [47:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH at %0t: word got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task check_reg(input [17:0] got, input [17:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task check_pins(input [2:0] exp);
      check_reg({15'h0000, general_output_bit_three, general_output_bit_two,
         general_output_bit_one}, {15'h0000, exp});
   endtask
   task conclude;
      begin
         $display("checks %0d errors %0d", check_count, err_count);
         if (err_count == 0 && check_count > 0) begin
            $display("bench passed");
         end else begin
            $display("bench failed");
         end
         $finish;
      end
   endtask
   initial begin
      repeat (16) @(negedge sys_clk);
      resetn = 1'b1;
      check_reg(gpo_ramp_gain_config, 18'h00003);
      check_reg({10'h000, digital_gain_db}, {10'h000, exp_gain(4'h3)});
      for (i = 0; i < 12; i = i + 1) begin
         cfg = rnd() & 18'h3FCCF;
         // First passes hit the top gain codes: 12, then the saturating codes 13 to 15
         if (i < 4) cfg[3:0] = {2'b11, i[1:0]};
         frequency_offset_word = rnd();
         afc = rnd();
         base_frequency_select = frequency_offset_word[1:0];
         i_host_serial_model.write(6'h02, cfg);
         i_host_serial_model.write(6'h03, frequency_offset_word);
         i_host_serial_model.write(6'h04, afc);
         i_host_serial_model.write(6'h05 + i[5:0], rnd());
         repeat (8) @(negedge sys_clk);
         check_reg(gpo_ramp_gain_config, cfg);
         check_reg(pll_frequency_offset, frequency_offset_word);
         check_reg(afc_signed_offset, afc);
         check_pins(idle_pins(cfg));
         check_reg({16'h0000, pll_preset_select}, {16'h0000, cfg[11:10]});
         check_reg({17'h00000, ramp_table_select}, {17'h00000, cfg[7]});
         check_reg({13'h0000, ramp_quarter_symbols}, {13'h0000, (cfg[6] ? 5'h0D : 5'h10)});
         check_reg({10'h000, digital_gain_db}, {10'h000, exp_gain(cfg[3:0])});
         check_word(lock_freq_fine, exp_freq(frequency_offset_word[1:0], frequency_offset_word, afc));
         override_enable = i[1];
         rx_override_pattern = frequency_offset_word[4:2];
         tx_override_duration = {4'h0, afc[3:0]};
         rx_override_duration = {4'h0, afc[7:4]};
         repeat (6) @(negedge sys_clk);
         tx_start_input = i[0];
         rx_enable_input = ~i[0];
         repeat (4) @(negedge sys_clk);
         check_pins(exp_pins(cfg, frequency_offset_word[4:2], i[1], i[0]));
         repeat (36) @(negedge sys_clk);
         check_pins(idle_pins(cfg));
         tx_start_input = 1'b0;
         rx_enable_input = 1'b0;
      end
      // Second reset in mid-run over non-default contents
      resetn = 1'b0;
      repeat (2) @(negedge sys_clk);
      resetn = 1'b1;
      check_reg(gpo_ramp_gain_config, 18'h00003);
      check_reg(afc_signed_offset, 18'h00000);
      check_reg({13'h0000, ramp_quarter_symbols}, {13'h0000, 5'h10});
      check_pins(3'h0);
      conclude;
   end
   initial begin
      #400000;
      err_count = err_count + 1;
      $display("MISMATCH at %0t: watchdog expired", $time);
      conclude;
   end
endmodule // gpo_pll_gain_offset_config_bench
